/* src/mmti_map.vh */
// Register indices, field positions, reset values and timing for the two-wire interface.
// Assumes a 32-bit Avalon-MM slave; byte address = 4 * index.
`ifndef MMTI_MAP_VH
`define MMTI_MAP_VH

`define MMTI_IDX_PCLK 10'h012
`define MMTI_IDX_DATA 10'h2B0
`define MMTI_IDX_OWNA 10'h2B2
`define MMTI_IDX_CTRL 10'h2B3
`define MMTI_IDX_BCLK 10'h2B4
`define MMTI_IDX_SSC 10'h2B5
`define MMTI_IDX_CTLB 10'h2B6
`define MMTI_IDX_CTLC 10'h2B7
`define MMTI_IDX_STA 10'h2B8
`define MMTI_IDX_STB 10'h2B9
`define MMTI_IDX_OWNB 10'h2BA
`define MMTI_IDX_OWNC 10'h2BB

`define MMTI_RST_PCLK 8'h03
`define MMTI_RST_ZERO 8'h00
`define MMTI_RST_SSC 8'h1A
`define MMTI_RST_CTLB 8'h30

// interface_control
`define MMTI_CTRL_EN 3
`define MMTI_CTRL_FMT 4
`define MMTI_CTRL_SRST 6
`define MMTI_CTRL_ILS 7
// bus_clock_control
`define MMTI_BCLK_FAST 5
`define MMTI_BCLK_ACKBIT 6
`define MMTI_BCLK_ACK_CLOCK_ENABLE 7
`define MMTI_RATE_SPECIAL 5'h05
// start_stop_control
`define MMTI_SSC_EPOL 5
`define MMTI_SSC_ESEL 6
// interface_control_c
`define MMTI_CTLC_TOEN 0
`define MMTI_CTLC_TOUT 1
`define MMTI_CTLC_MULTI 2
// bus_status_a
`define MMTI_STA_GCALL 0
`define MMTI_STA_MATCH 1
`define MMTI_STA_ARB 2
`define MMTI_STA_PEND_N 4
`define MMTI_STA_BUSY 5
`define MMTI_STA_DIR 6
`define MMTI_STA_MASTER 7

`define MMTI_GCALL_ADDR 8'h00
`define MMTI_CLK_HZ 40000000
`define MMTI_VIIC_HZ 4000000
`define MMTI_TOUT_US 100
`define MMTI_SRST_TICKS 2'h2

`endif

/* src/mmti_sync2.v */
// Two-flop synchroniser for the two bus lines.
// Assumes asynchronous pin inputs; the first stage feeds only the second.
`timescale 1ns/1ps
module mmti_sync2 (
	input wire clk_in,
	input wire resetn_in,
	input wire [1:0] async_in,
	output wire [1:0] sync_out
);
	reg [1:0] meta_q;
	reg [1:0] sync_q;

	// Idle bus is high, so reset to high avoids false edges at release
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_q <= 2'h3;
			sync_q <= 2'h3;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule

/* src/mmti_top.v */
// Multi-master two-wire serial interface with Avalon-MM register access.
// Assumes open-drain pads outside; pins arrive asynchronously to clk_in.
// Contract
// - Four master/slave roles, standard and fast rates
// - Both bus lines open drain, pull low only
// - Slave acks own address or general call, or any first byte in free format, else stays silent
// - Three 7-bit own addresses, zero means unused
// - Multi-address off: only first address compared
// - Addressed format: request on match or general call
// - Free format: request on first byte always
// - Arbitration lost: release line, set flag
// - Bus busy set on start, cleared on stop
// - Busy and clock long high: timeout flag
// - Transmit bit 7 first, shift left
// - Receive into bit 0, shift left
// - Master start and stop via data writes
// - Bit count clears on start or stop
// - Bit count clears after byte and ack
// - Disabled: pins released, flags cleared, clock stopped
// - Soft reset clears flags, self-clears quickly
// - Input level select for both pins
// - Edge interrupt on chosen line and polarity
// - Optional ninth ack clock; else request on eighth
`timescale 1ns/1ps
`include "mmti_map.vh"
module mmti_top (
	input wire clk_in,
	input wire resetn_in,
	input wire [11:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [3:0] avs_byteenable_in,
	input wire [31:0] avs_writedata_in,
	output wire [31:0] avs_readdata_out,
	output wire avs_waitrequest_out,
	input wire bus_clock_pin_in,
	output wire bus_clock_pin_out,
	output wire bus_clock_pin_oe_n_out,
	input wire bus_data_pin_in,
	output wire bus_data_pin_out,
	output wire bus_data_pin_oe_n_out,
	output wire pin_function_select_out,
	output wire input_level_select_out,
	output wire bus_irq_out,
	output wire edge_irq_out
);
	localparam integer VIIC_DIV_I = `MMTI_CLK_HZ / `MMTI_VIIC_HZ;
	localparam integer TOUT_TICKS_I = `MMTI_TOUT_US * (`MMTI_VIIC_HZ / 1000000);
	localparam [3:0] VIIC_DIV = VIIC_DIV_I[3:0];
	localparam [8:0] TOUT_TICKS = TOUT_TICKS_I[8:0];
	localparam [4:0] MS_IDLE = 5'h01;
	localparam [4:0] MS_START = 5'h02;
	localparam [4:0] MS_RUN = 5'h04;
	localparam [4:0] MS_STOP1 = 5'h08;
	localparam [4:0] MS_STOP2 = 5'h10;

	reg [7:0] pclk_q, owna_q, ownb_q, ownc_q, ctrl_q, bclk_q, ssc_q, ctlb_q, ctlc_q;
	reg [7:0] data_q;
	reg [1:0] srst_cnt_q;
	reg ack_q;
	reg [31:0] rdata_q;
	reg [7:0] rd_val;
	reg gcall_q, match_q, arb_lost_q, pend_n_q, busy_q, dir_tx_q, master_q, busy_req_q;
	reg [2:0] slot_q;
	reg tout_q;
	reg [8:0] tout_cnt_q;
	reg [3:0] div_q;
	reg scl_r, sda_r;
	reg [3:0] bitcnt_q;
	reg ack_ph_q, addr_ph_q, part_q, hold_q;
	reg sda_drv_q, scl_drv_q;
	reg [4:0] ms_q;
	reg [6:0] tmr_q;
	reg edge_irq_q;

	wire [1:0] pins_s;
	wire scl_s = pins_s[1];
	wire sda_s = pins_s[0];
	wire en = ctrl_q[`MMTI_CTRL_EN];
	wire clr = ~en | ctrl_q[`MMTI_CTRL_SRST];
	wire [9:0] idx = avs_address_in[11:2];
	wire [7:0] wd8 = avs_writedata_in[7:0];
	wire wr_ok = avs_write_in & ack_q & avs_byteenable_in[0];
	wire tick = en & (div_q == VIIC_DIV - 4'h1);
	wire fmt = ctrl_q[`MMTI_CTRL_FMT];
	wire ackbit = bclk_q[`MMTI_BCLK_ACKBIT];
	wire ack_clock_en = bclk_q[`MMTI_BCLK_ACK_CLOCK_ENABLE];
	wire [4:0] rate = bclk_q[4:0];

	mmti_sync2 i_mmti_sync2 (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.async_in({bus_clock_pin_in, bus_data_pin_in}),
		.sync_out(pins_s)
	);

	wire scl_rise = scl_s & ~scl_r;
	wire scl_fall = ~scl_s & scl_r;
	wire start_det = scl_s & scl_r & sda_r & ~sda_s;
	wire stop_det = scl_s & scl_r & ~sda_r & sda_s;
	wire [3:0] nbits = (ctrl_q[2:0] == 3'h0) ? 4'h8 : {1'b0, ctrl_q[2:0]};
	wire listen = busy_q & (part_q | addr_ph_q) & ~ms_q[3] & ~ms_q[4];
	wire data_done = bitcnt_q >= nbits;
	wire byte_end = listen & scl_fall & data_done & (ack_ph_q | ~ack_clock_en);
	wire data_wr = wr_ok & (idx == `MMTI_IDX_DATA) & en;

	// Fast mode at the special rate value runs at a hundredth of the system clock
	wire [6:0] half = bclk_q[`MMTI_BCLK_FAST] ?
		((rate == `MMTI_RATE_SPECIAL) ? {2'h0, rate} : {1'b0, rate, 1'b0}) :
		{rate, 2'b00};

	wire [23:0] own_v = {ownc_q, ownb_q, owna_q};
	wire [2:0] hit;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_slot
			wire [6:0] own = own_v[8*gi+7 -: 7];
			wire slot_on = (gi == 0) | ctlc_q[`MMTI_CTLC_MULTI];
			assign hit[gi] = slot_on & (own != 7'h00) & (own == data_q[7:1]);
		end
	endgenerate
	wire gcall = data_q == `MMTI_GCALL_ADDR;
	wire accept = fmt | (|hit) | gcall;
	wire part_now = addr_ph_q ? accept : part_q;

	// Avalon: one wait cycle, then the access completes
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
	assign avs_readdata_out = rdata_q;

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
			if (avs_read_in & ~ack_q)
				rdata_q <= {24'h000000, rd_val};
		end
	end

	always @* begin
		rd_val = 8'h00;
		if (idx == `MMTI_IDX_PCLK) begin
			rd_val = pclk_q;
		end else if (idx == `MMTI_IDX_DATA) begin
			rd_val = data_q;
		end else if (idx == `MMTI_IDX_OWNA) begin
			rd_val = owna_q;
		end else if (idx == `MMTI_IDX_CTRL) begin
			rd_val = ctrl_q;
		end else if (idx == `MMTI_IDX_BCLK) begin
			rd_val = bclk_q;
		end else if (idx == `MMTI_IDX_SSC) begin
			rd_val = ssc_q;
		end else if (idx == `MMTI_IDX_CTLB) begin
			rd_val = ctlb_q;
		end else if (idx == `MMTI_IDX_CTLC) begin
			rd_val = {ctlc_q[7:2], tout_q, ctlc_q[0]};
		end else if (idx == `MMTI_IDX_STA) begin
			rd_val = {master_q, dir_tx_q, busy_q, pend_n_q, 1'b0, arb_lost_q, match_q, gcall_q};
		end else if (idx == `MMTI_IDX_STB) begin
			rd_val = {5'h00, slot_q};
		end else if (idx == `MMTI_IDX_OWNB) begin
			rd_val = ownb_q;
		end else if (idx == `MMTI_IDX_OWNC) begin
			rd_val = ownc_q;
		end
	end

	// Configuration registers
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pclk_q <= `MMTI_RST_PCLK;
			owna_q <= `MMTI_RST_ZERO;
			ownb_q <= `MMTI_RST_ZERO;
			ownc_q <= `MMTI_RST_ZERO;
			ctrl_q <= `MMTI_RST_ZERO;
			bclk_q <= `MMTI_RST_ZERO;
			ssc_q <= `MMTI_RST_SSC;
			ctlb_q <= `MMTI_RST_CTLB;
			ctlc_q <= `MMTI_RST_ZERO;
			srst_cnt_q <= 2'h0;
		end else begin
			if (wr_ok) begin
				if (idx == `MMTI_IDX_PCLK) begin
					pclk_q <= wd8;
				end else if (idx == `MMTI_IDX_OWNA) begin
					owna_q <= {wd8[7:1], 1'b0};
				end else if (idx == `MMTI_IDX_OWNB) begin
					ownb_q <= {wd8[7:1], 1'b0};
				end else if (idx == `MMTI_IDX_OWNC) begin
					ownc_q <= {wd8[7:1], 1'b0};
				end else if (idx == `MMTI_IDX_CTRL) begin
					// Soft reset can only be armed while already enabled
					ctrl_q <= {wd8[7], wd8[6] & en, 1'b0, wd8[4:0]};
				end else if (idx == `MMTI_IDX_BCLK) begin
					bclk_q <= wd8;
				end else if (idx == `MMTI_IDX_SSC) begin
					ssc_q <= wd8;
				end else if (idx == `MMTI_IDX_CTLB) begin
					ctlb_q <= wd8;
				end else if (idx == `MMTI_IDX_CTLC) begin
					ctlc_q <= {5'h00, wd8[`MMTI_CTLC_MULTI], 1'b0, wd8[`MMTI_CTLC_TOEN]};
				end
			end
			if (start_det | stop_det | byte_end)
				ctrl_q[2:0] <= 3'h0;
			if (!ctrl_q[`MMTI_CTRL_SRST] | ~en) begin
				srst_cnt_q <= 2'h0;
				if (~en)
					ctrl_q[`MMTI_CTRL_SRST] <= 1'b0;
			end else if (tick) begin
				srst_cnt_q <= srst_cnt_q + 2'h1;
				if (srst_cnt_q == `MMTI_SRST_TICKS - 2'h1)
					ctrl_q[`MMTI_CTRL_SRST] <= 1'b0;
			end
		end
	end

	// System clock enable stops while disabled
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			div_q <= 4'h0;
		end else if (~en | tick) begin
			div_q <= 4'h0;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tout_cnt_q <= 9'h000;
			tout_q <= 1'b0;
		end else if (clr) begin
			tout_cnt_q <= 9'h000;
			tout_q <= 1'b0;
		end else if (~busy_q | ~scl_s) begin
			tout_cnt_q <= 9'h000;
		end else if (tick) begin
			if (tout_cnt_q == TOUT_TICKS)
				tout_q <= 1'b1;
			else
				tout_cnt_q <= tout_cnt_q + 9'h001;
		end
	end

	wire esel = ssc_q[`MMTI_SSC_ESEL] ? scl_s : sda_s;
	wire esel_r = ssc_q[`MMTI_SSC_ESEL] ? scl_r : sda_r;
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			edge_irq_q <= 1'b0;
		else
			edge_irq_q <= en & (esel != esel_r) & (esel == ssc_q[`MMTI_SSC_EPOL]);
	end

	// Bus engine, status flags and master clock generator
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			data_q <= 8'h00;
			gcall_q <= 1'b0;
			match_q <= 1'b0;
			arb_lost_q <= 1'b0;
			pend_n_q <= 1'b1;
			busy_q <= 1'b0;
			dir_tx_q <= 1'b0;
			master_q <= 1'b0;
			busy_req_q <= 1'b0;
			slot_q <= 3'h0;
			bitcnt_q <= 4'h0;
			ack_ph_q <= 1'b0;
			addr_ph_q <= 1'b0;
			part_q <= 1'b0;
			hold_q <= 1'b0;
			sda_drv_q <= 1'b0;
			scl_drv_q <= 1'b0;
			ms_q <= MS_IDLE;
			tmr_q <= 7'h00;
		end else begin
			scl_r <= scl_s;
			sda_r <= sda_s;
			if (clr) begin
				gcall_q <= 1'b0;
				match_q <= 1'b0;
				arb_lost_q <= 1'b0;
				pend_n_q <= 1'b1;
				busy_q <= 1'b0;
				dir_tx_q <= 1'b0;
				master_q <= 1'b0;
				busy_req_q <= 1'b0;
				slot_q <= 3'h0;
				bitcnt_q <= 4'h0;
				ack_ph_q <= 1'b0;
				addr_ph_q <= 1'b0;
				part_q <= 1'b0;
				hold_q <= 1'b0;
				sda_drv_q <= 1'b0;
				scl_drv_q <= 1'b0;
				ms_q <= MS_IDLE;
				tmr_q <= 7'h00;
			end else begin
				if (start_det) begin
					busy_q <= 1'b1;
					bitcnt_q <= 4'h0;
					ack_ph_q <= 1'b0;
					addr_ph_q <= ~master_q;
					part_q <= master_q;
				end else if (stop_det) begin
					busy_q <= 1'b0;
					bitcnt_q <= 4'h0;
					ack_ph_q <= 1'b0;
					addr_ph_q <= 1'b0;
					part_q <= 1'b0;
					hold_q <= 1'b0;
					sda_drv_q <= 1'b0;
					scl_drv_q <= 1'b0;
					master_q <= 1'b0;
					dir_tx_q <= 1'b0;
				end else if (listen & scl_rise) begin
					if (!ack_ph_q) begin
						data_q <= {data_q[6:0], sda_s};
						bitcnt_q <= bitcnt_q + 4'h1;
						if (master_q & dir_tx_q & ~sda_drv_q & ~sda_s) begin
							arb_lost_q <= 1'b1;
							pend_n_q <= 1'b0;
							master_q <= 1'b0;
							dir_tx_q <= 1'b0;
							part_q <= 1'b0;
						end
					end else if (~master_q & dir_tx_q & sda_s) begin
						// Not acknowledged: a slave transmitter stops here
						part_q <= 1'b0;
					end
				end else if (listen & scl_fall) begin
					if (!data_done) begin
						if (part_q & dir_tx_q)
							sda_drv_q <= ~data_q[7];
					end else if (!ack_ph_q) begin
						if (addr_ph_q) begin
							addr_ph_q <= 1'b0;
							part_q <= accept;
							match_q <= ~fmt & (|hit);
							slot_q <= fmt ? 3'h0 : hit;
							gcall_q <= ~fmt & gcall;
							dir_tx_q <= ~fmt & accept & data_q[0];
						end
						if (ack_clock_en) begin
							ack_ph_q <= 1'b1;
							sda_drv_q <= ~ackbit & (addr_ph_q ? accept : (part_q & ~dir_tx_q));
						end
					end
					if (byte_end) begin
						bitcnt_q <= 4'h0;
						ack_ph_q <= 1'b0;
						sda_drv_q <= 1'b0;
						if (part_now) begin
							pend_n_q <= 1'b0;
							hold_q <= 1'b1;
							scl_drv_q <= 1'b1;
						end
					end
				end

				if (wr_ok & (idx == `MMTI_IDX_STA)) begin
					master_q <= wd8[`MMTI_STA_MASTER];
					dir_tx_q <= wd8[`MMTI_STA_DIR];
					busy_req_q <= wd8[`MMTI_STA_BUSY];
				end

				// A data write also starts or stops the bus as master
				if (data_wr) begin
					pend_n_q <= 1'b1;
					hold_q <= 1'b0;
					tmr_q <= 7'h00;
					if (master_q & ~busy_q & busy_req_q) begin
						data_q <= wd8;
						sda_drv_q <= 1'b1;
						ms_q <= MS_START;
					end else if (master_q & busy_q & ~busy_req_q) begin
						sda_drv_q <= 1'b1;
						scl_drv_q <= 1'b1;
						ms_q <= MS_STOP1;
					end else begin
						data_q <= wd8;
						sda_drv_q <= part_q & dir_tx_q & ~wd8[7];
						if (!master_q)
							scl_drv_q <= 1'b0;
					end
				end else begin
					case (ms_q)
						MS_START: begin
							if (tick) begin
								tmr_q <= tmr_q + 7'h01;
								if (tmr_q == half - 7'h01) begin
									scl_drv_q <= 1'b1;
									tmr_q <= 7'h00;
									ms_q <= MS_RUN;
								end
							end
						end
						MS_RUN: begin
							if (~master_q | ~busy_q) begin
								scl_drv_q <= 1'b0;
								ms_q <= MS_IDLE;
							end else if (scl_drv_q) begin
								if (hold_q | (listen & scl_fall & data_done & ~ack_ph_q & ~ack_clock_en)) begin
									tmr_q <= 7'h00;
								end else if (tick) begin
									tmr_q <= tmr_q + 7'h01;
									if (tmr_q == half - 7'h01) begin
										scl_drv_q <= 1'b0;
										tmr_q <= 7'h00;
									end
								end
							end else if (~scl_s) begin
								// Another device stretches the clock low
								tmr_q <= 7'h00;
							end else if (tick) begin
								tmr_q <= tmr_q + 7'h01;
								if (tmr_q == half - 7'h01) begin
									scl_drv_q <= 1'b1;
									tmr_q <= 7'h00;
								end
							end
						end
						MS_STOP1: begin
							if (tick) begin
								tmr_q <= tmr_q + 7'h01;
								if (tmr_q == half - 7'h01) begin
									scl_drv_q <= 1'b0;
									tmr_q <= 7'h00;
									ms_q <= MS_STOP2;
								end
							end
						end
						MS_STOP2: begin
							if (~scl_s) begin
								tmr_q <= 7'h00;
							end else if (tick) begin
								tmr_q <= tmr_q + 7'h01;
								if (tmr_q == half - 7'h01) begin
									sda_drv_q <= 1'b0;
									tmr_q <= 7'h00;
									ms_q <= MS_IDLE;
								end
							end
						end
						default: begin
							tmr_q <= 7'h00;
						end
					endcase
				end
			end
		end
	end

	// Open drain: value always low, enable low only while pulling
	assign bus_clock_pin_out = 1'b0;
	assign bus_data_pin_out = 1'b0;
	assign bus_clock_pin_oe_n_out = ~scl_drv_q;
	assign bus_data_pin_oe_n_out = ~sda_drv_q;
	assign pin_function_select_out = en;
	assign input_level_select_out = ctrl_q[`MMTI_CTRL_ILS];
	assign bus_irq_out = ~pend_n_q | (tout_q & ctlc_q[`MMTI_CTLC_TOEN]);
	assign edge_irq_out = edge_irq_q;
endmodule

/* sim/mmti_top_assertions.sv */
// Port-level assertions for the two-wire interface top.
// Assumes it is bound to mmti_top and sees only that module's ports.
`timescale 1ns/1ps
module mmti_top_assertions (
	input wire clk_in,
	input wire resetn_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_readdata_out,
	input wire avs_waitrequest_out,
	input wire bus_clock_pin_in,
	input wire bus_data_pin_in,
	input wire bus_clock_pin_out,
	input wire bus_clock_pin_oe_n_out,
	input wire bus_data_pin_out,
	input wire bus_data_pin_oe_n_out,
	input wire pin_function_select_out,
	input wire bus_irq_out,
	input wire edge_irq_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	property p_answer;
		(avs_read_in || avs_write_in) |-> ##[0:1] !avs_waitrequest_out;
	endproperty
	a_answer: assert property (p_answer)
		else $error("register access not answered in time");
	property p_single;
		(avs_read_in || avs_write_in) && !avs_waitrequest_out
			|=> avs_waitrequest_out || !(avs_read_in || avs_write_in);
	endproperty
	a_single: assert property (p_single)
		else $error("second access answered without wait");
	// Read data must survive until the next read so slow masters can take it
	property p_hold;
		!$past(avs_read_in) |-> $stable(avs_readdata_out);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data changed without a read");
	property p_pins_low;
		!bus_clock_pin_out && !bus_data_pin_out;
	endproperty
	a_pins_low: assert property (p_pins_low)
		else $error("bus pin drives high");
	property p_released;
		!pin_function_select_out && !$past(pin_function_select_out)
			|-> bus_clock_pin_oe_n_out && bus_data_pin_oe_n_out;
	endproperty
	a_released: assert property (p_released)
		else $error("bus line pulled while disabled");
	property p_quiet;
		!pin_function_select_out && !$past(pin_function_select_out) |-> !bus_irq_out;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("bus request while disabled");
	property p_pulse;
		edge_irq_out |=> !edge_irq_out;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("edge request longer than one cycle");
	property p_cause;
		edge_irq_out |-> ($past(bus_clock_pin_in) != $past(bus_clock_pin_in, 5))
			|| ($past(bus_data_pin_in) != $past(bus_data_pin_in, 5));
	endproperty
	a_cause: assert property (p_cause)
		else $error("edge request without a line change");
endmodule

bind mmti_top mmti_top_assertions i_mmti_top_assertions (
	.clk_in(clk_in), .resetn_in(resetn_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out), .bus_clock_pin_in(bus_clock_pin_in),
	.bus_data_pin_in(bus_data_pin_in), .bus_clock_pin_out(bus_clock_pin_out),
	.bus_clock_pin_oe_n_out(bus_clock_pin_oe_n_out), .bus_data_pin_out(bus_data_pin_out),
	.bus_data_pin_oe_n_out(bus_data_pin_oe_n_out),
	.pin_function_select_out(pin_function_select_out), .bus_irq_out(bus_irq_out),
	.edge_irq_out(edge_irq_out)
);

/* sim/mmti_far_master.sv */
// Behavioural master on the far side of the two-wire bus, 200 ns bit period.
// Assumes the bench resolves both open-drain lines with pull-ups and feeds them back.
`timescale 1ns/1ps
module mmti_far_master (
	input wire scl_in,
	input wire sda_in,
	output logic scl_rel_out,
	output logic sda_rel_out
);
	initial begin
		scl_rel_out = 1'b1;
		sda_rel_out = 1'b1;
	end
	// A slave may stretch the low phase; the bench timeout bounds the wait
	task automatic rise_clock;
		#50 scl_rel_out = 1'b1;
		#1;
		if (scl_in !== 1'b1) begin
			wait (scl_in === 1'b1);
			#7;
		end
	endtask
	task automatic clock_pulse(output logic seen);
		rise_clock;
		#96 seen = sda_in;
		#3 scl_rel_out = 1'b0;
	endtask
	task automatic start_cond;
		#7 sda_rel_out = 1'b0;
		#100 scl_rel_out = 1'b0;
	endtask
	task automatic send_byte(input logic [7:0] b, output logic acked);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			#50 sda_rel_out = b[i];
			clock_pulse(s);
		end
		#50 sda_rel_out = 1'b1;
		clock_pulse(s);
		acked = ~s;
	endtask
	task automatic stop_cond;
		#50 sda_rel_out = 1'b0;
		rise_clock;
		#99 sda_rel_out = 1'b1;
		#100;
	endtask
endmodule

/* sim/multi_master_twowire_interface_test.sv */
// Self-checking bench: register access and slave traffic of the two-wire interface.
// Assumes mmti_top, the far-side master model and the bound checker.
`timescale 1ns/1ps
`include "mmti_map.vh"
module multi_master_twowire_interface_test;
	localparam int TIMEOUT = 20000;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [11:0] avs_address_in = 12'h000;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [3:0] avs_byteenable_in = 4'hF;
	logic [31:0] avs_writedata_in = 32'h0;
	wire [31:0] avs_readdata_out;
	wire avs_waitrequest_out, scl_out, scl_oe_n, sda_out, sda_oe_n, pfs, ils;
	wire bus_irq_out, edge_irq_out, scl_rel, sda_rel;
	// Pull-ups: a line is low while any party pulls it
	wire scl_line = scl_rel & (scl_oe_n | scl_out);
	wire sda_line = sda_rel & (sda_oe_n | sda_out);
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	int edge_count = 0;
	mmti_top i_mmti_top (
		.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_byteenable_in(avs_byteenable_in), .avs_writedata_in(avs_writedata_in),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.bus_clock_pin_in(scl_line), .bus_clock_pin_out(scl_out),
		.bus_clock_pin_oe_n_out(scl_oe_n), .bus_data_pin_in(sda_line),
		.bus_data_pin_out(sda_out), .bus_data_pin_oe_n_out(sda_oe_n),
		.pin_function_select_out(pfs), .input_level_select_out(ils),
		.bus_irq_out(bus_irq_out), .edge_irq_out(edge_irq_out)
	);
	mmti_far_master i_mmti_far_master (.scl_in(scl_line), .sda_in(sda_line),
		.scl_rel_out(scl_rel), .sda_rel_out(sda_rel));
	initial begin
		forever #12.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (edge_irq_out === 1'b1)
			edge_count <= edge_count + 1;
		if (cycles == TIMEOUT) begin
			errors = errors + 1;
			final_report;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic chk1(input logic seen, input logic exp);
		chk({31'h0, seen}, {31'h0, exp});
	endtask
	task automatic bus_write(input logic [9:0] idx, input logic [7:0] val);
		@(posedge clk_in);
		avs_address_in <= {idx, 2'b00};
		avs_writedata_in <= {24'h000000, val};
		avs_write_in <= 1'b1;
		do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
		avs_write_in <= 1'b0;
	endtask
	task automatic bus_read(input logic [9:0] idx, output logic [7:0] val);
		@(posedge clk_in);
		avs_address_in <= {idx, 2'b00};
		avs_read_in <= 1'b1;
		do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
		val = avs_readdata_out[7:0];
		avs_read_in <= 1'b0;
	endtask
	task automatic expect_reg(input logic [9:0] idx, input logic [7:0] exp);
		logic [7:0] v;
		bus_read(idx, v);
		chk({24'h000000, v}, {24'h000000, exp});
	endtask
	// With the ack clock on and ackbit clear, acknowledge and bus request go together for an address byte
	task automatic frame_start(input logic [7:0] b, input logic exp_ack);
		logic acked;
		i_mmti_far_master.start_cond;
		i_mmti_far_master.send_byte(b, acked);
		for (int n = 0; n < 12 && bus_irq_out !== exp_ack; n++)
			@(posedge clk_in);
		chk1(acked, exp_ack);
		chk1(bus_irq_out, exp_ack);
	endtask
	task automatic finish_frame;
		bus_write(`MMTI_IDX_DATA, 8'h00);
		i_mmti_far_master.stop_cond;
	endtask
	task automatic t_reset_values;
		expect_reg(`MMTI_IDX_PCLK, `MMTI_RST_PCLK);
		expect_reg(`MMTI_IDX_SSC, `MMTI_RST_SSC);
		expect_reg(`MMTI_IDX_CTLB, `MMTI_RST_CTLB);
		expect_reg(`MMTI_IDX_CTRL, 8'h00);
		expect_reg(`MMTI_IDX_STA, 8'h10);
		expect_reg(`MMTI_IDX_OWNB, 8'h00);
		bus_write(10'h100, 8'hFF);
		expect_reg(10'h100, 8'h00);
		$display("reset values test done");
	endtask
	task automatic t_addressed;
		int e0;
		logic acked;
		logic [7:0] v;
		bus_write(`MMTI_IDX_BCLK, 8'h83);
		bus_write(`MMTI_IDX_SSC, 8'h7A);
		bus_write(`MMTI_IDX_CTRL, 8'h08);
		bus_write(`MMTI_IDX_OWNA, 8'h58);
		chk1(pfs, 1'b1);
		expect_reg(`MMTI_IDX_OWNA, 8'h58);
		e0 = edge_count;
		frame_start(8'h58, 1'b1);
		chk(edge_count - e0, 32'h9);
		expect_reg(`MMTI_IDX_STA, 8'h22);
		expect_reg(`MMTI_IDX_STB, 8'h01);
		bus_write(`MMTI_IDX_DATA, 8'h00);
		i_mmti_far_master.send_byte(8'hA5, acked);
		chk1(acked, 1'b1);
		expect_reg(`MMTI_IDX_DATA, 8'hA5);
		finish_frame;
		bus_read(`MMTI_IDX_STA, v);
		chk({24'h0, v & 8'h30}, 32'h10);
		expect_reg(`MMTI_IDX_CTRL, 8'h08);
		$display("addressed receive test done");
	endtask
	task automatic t_multi;
		logic [7:0] v;
		bus_write(`MMTI_IDX_OWNB, 8'h66);
		frame_start(8'h66, 1'b0);
		i_mmti_far_master.stop_cond;
		bus_write(`MMTI_IDX_CTLC, 8'h04);
		frame_start(8'h66, 1'b1);
		expect_reg(`MMTI_IDX_STB, 8'h02);
		finish_frame;
		frame_start(`MMTI_GCALL_ADDR, 1'b1);
		bus_read(`MMTI_IDX_STA, v);
		chk({24'h0, v & 8'h01}, 32'h1);
		finish_frame;
		$display("address slots test done");
	endtask
	task automatic t_free;
		bus_write(`MMTI_IDX_CTRL, 8'h18);
		frame_start(8'hF2, 1'b1);
		finish_frame;
		$display("free format test done");
	endtask
	task automatic t_soft_reset;
		logic [7:0] v;
		bus_write(`MMTI_IDX_CTRL, 8'h08);
		frame_start(8'h58, 1'b1);
		bus_write(`MMTI_IDX_CTRL, 8'h48);
		v = 8'h40;
		for (int n = 0; n < 12 && v[6] !== 1'b0; n++)
			bus_read(`MMTI_IDX_CTRL, v);
		chk({24'h0, v}, 32'h08);
		expect_reg(`MMTI_IDX_STA, 8'h10);
		expect_reg(`MMTI_IDX_STB, 8'h00);
		i_mmti_far_master.stop_cond;
		$display("soft reset test done");
	endtask
	// Busy bus with the clock line parked high must flag after 400 ticks
	task automatic t_timeout;
		bus_write(`MMTI_IDX_CTLC, 8'h05);
		i_mmti_far_master.start_cond;
		i_mmti_far_master.rise_clock;
		repeat (3800) @(posedge clk_in);
		expect_reg(`MMTI_IDX_CTLC, 8'h05);
		repeat (400) @(posedge clk_in);
		expect_reg(`MMTI_IDX_CTLC, 8'h07);
		chk1(bus_irq_out, 1'b1);
		i_mmti_far_master.stop_cond;
		$display("timeout test done");
	endtask
	task automatic t_disable;
		logic [7:0] d0;
		bus_write(`MMTI_IDX_CTRL, 8'h88);
		@(posedge clk_in);
		chk1(ils, 1'b1);
		bus_read(`MMTI_IDX_DATA, d0);
		bus_write(`MMTI_IDX_CTRL, 8'h00);
		@(posedge clk_in);
		chk1(pfs, 1'b0);
		chk1(ils, 1'b0);
		bus_write(`MMTI_IDX_DATA, ~d0);
		expect_reg(`MMTI_IDX_DATA, d0);
		expect_reg(`MMTI_IDX_STA, 8'h10);
		$display("disable test done");
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_in);
		resetn_in <= 1'b1;
		t_reset_values;
		t_addressed;
		t_multi;
		t_free;
		t_soft_reset;
		t_timeout;
		t_disable;
		final_report;
	end
endmodule
